// >>> rtl/bfh_host.sv
// Host controller for a parallel boot-sector flash
module bfh_host #(
	parameter int READY_CYCLES = bfh_pkg::READY_CYC
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Request
	input wire logic req_valid,
	output logic req_ready,
	input wire bfh_pkg::bfh_op_t req_op,
	input wire logic req_word,
	input wire logic [19:0] req_addr,
	input wire logic [15:0] req_wdata,
	// Answer
	output logic rsp_valid,
	output logic [15:0] rsp_rdata,
	output logic [4:0] rsp_sector,
	output logic dev_busy,
	// Flash pins
	output logic ce_n,
	output logic oe_n,
	output logic we_n,
	output logic reset_n,
	output logic byte_n,
	output logic [18:0] addr,
	output logic [15:0] dq_out,
	output logic [15:0] dq_oe,
	input wire logic [15:0] dq_in,
	input wire logic ready_busy_out
);
	// ----------------------------------------
	// Pad stage
	// ----------------------------------------
	bfh_if pins ();
	logic [15:0] dq_sync;
	logic rb_sync;
	bfh_pads u_pads (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.p(pins.pad),
		.ce_n(ce_n),
		.oe_n(oe_n),
		.we_n(we_n),
		.reset_n(reset_n),
		.byte_n(byte_n),
		.addr(addr),
		.dq_out(dq_out),
		.dq_oe(dq_oe),
		.dq_in(dq_in),
		.ready_busy_in(ready_busy_out),
		.dq_sync(dq_sync),
		.rb_sync(rb_sync)
	);
	// ----------------------------------------
	// Sequencer state
	// ----------------------------------------
	bfh_pkg::bfh_state_t state;
	bfh_pkg::bfh_state_t next_state;
	bfh_pkg::bfh_op_t op;
	logic word;
	logic [19:0] a;
	logic [15:0] wd;
	logic [15:0] cnt;
	logic [15:0] next_cnt;
	logic recovered;
	wire idle = state == bfh_pkg::BFH_IDLE;
	wire take = req_valid && req_ready;
	wire cnt_done = cnt == 16'h0000;
	wire is_read = op == bfh_pkg::BFH_OP_READ;
	wire is_write = op == bfh_pkg::BFH_OP_WRITE;
	wire active = state == bfh_pkg::BFH_SETUP ||
		state == bfh_pkg::BFH_STROBE || state == bfh_pkg::BFH_HOLD;
	// Accesses wait for recovery after reset; reads also work while
	// busy, since status reads are legal then
	assign req_ready = idle && recovered;
	assign dev_busy = !rb_sync;
	// Sector bits are A18 to A12 in either width
	wire [6:0] sect_bits = req_word ? req_addr[18:12] : req_addr[19:13];
	// ----------------------------------------
	// Pin drive
	// ----------------------------------------
	wire strobe = state == bfh_pkg::BFH_STROBE;
	wire in_rst = state == bfh_pkg::BFH_RST;
	// Chip select only during an access; standby otherwise
	assign pins.ce_n = !(active && !in_rst);
	assign pins.oe_n = !(active && is_read);
	assign pins.we_n = !(strobe && is_write);
	assign pins.rst_n = !in_rst;
	assign pins.word_mode = word;
	// Byte mode: address bit 0 of the request is A-1 on line 15
	assign pins.addr = word ? a[18:0] : a[19:1];
	assign pins.dout = word ? wd : {a[0], 7'h00, wd[7:0]};
	// Never fight the device while it drives a read
	assign pins.doe = (active && is_write) ?
		(word ? 16'hFFFF : 16'h80FF) :
		((active && !word) ? 16'h8000 : 16'h0000);
	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_state = state;
		next_cnt = cnt_done ? cnt : cnt - 16'h0001;
		unique case (state)
			bfh_pkg::BFH_IDLE: begin
				if (take && req_op == bfh_pkg::BFH_OP_RESET) begin
					next_state = bfh_pkg::BFH_RST;
					next_cnt = 16'(bfh_pkg::RP_CYC);
				end else if (take) begin
					next_state = bfh_pkg::BFH_SETUP;
					next_cnt = 16'h0000;
				end
			end
			bfh_pkg::BFH_SETUP: begin
				next_state = bfh_pkg::BFH_STROBE;
				next_cnt = is_read ? 16'(bfh_pkg::ACC_CYC) :
					16'(bfh_pkg::WP_CYC);
			end
			bfh_pkg::BFH_STROBE: begin
				if (cnt_done) begin
					next_state = bfh_pkg::BFH_HOLD;
				end
			end
			bfh_pkg::BFH_HOLD: begin
				// One full bus cycle per write; bypass is two requests
				next_state = bfh_pkg::BFH_IDLE;
			end
			bfh_pkg::BFH_RST: begin
				if (cnt_done) begin
					next_state = bfh_pkg::BFH_RWAIT;
					next_cnt = 16'(READY_CYCLES);
				end
			end
			bfh_pkg::BFH_RWAIT: begin
				// Wait ready time, and for busy to clear if it was
				if (cnt_done && rb_sync) begin
					next_state = bfh_pkg::BFH_IDLE;
					next_cnt = 16'(bfh_pkg::RH_CYC);
				end
			end
			default: begin
				next_state = bfh_pkg::BFH_IDLE;
			end
		endcase
	end
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			state <= bfh_pkg::BFH_IDLE;
			cnt <= 16'h0000;
			op <= bfh_pkg::BFH_OP_READ;
			word <= 1'b1;
			a <= 20'h00000;
			wd <= 16'h0000;
			recovered <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			if (take) begin
				op <= req_op;
				word <= req_word;
				a <= req_addr;
				wd <= req_wdata;
			end
			// Post-reset read recovery
			if (state == bfh_pkg::BFH_RWAIT)
				recovered <= 1'b0;
			else if (idle && !recovered && cnt_done)
				recovered <= 1'b1;
		end
	end
	// ----------------------------------------
	// Answer
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			rsp_valid <= 1'b0;
			rsp_rdata <= 16'h0000;
			rsp_sector <= bfh_pkg::SECT_ZERO;
		end else begin
			rsp_valid <= state == bfh_pkg::BFH_HOLD ||
				(state == bfh_pkg::BFH_RWAIT && next_state == bfh_pkg::BFH_IDLE);
			if (state == bfh_pkg::BFH_HOLD && is_read)
				rsp_rdata <= word ? dq_sync : {8'h00, dq_sync[7:0]};
			if (take)
				rsp_sector <= bfh_pkg::sector_of(sect_bits);
		end
	end
endmodule // bfh_host

// >>> rtl/bfh_if.sv
// Interface: pin bundle between sequencer and pad stage
interface bfh_if;
	logic ce_n;
	logic oe_n;
	logic we_n;
	logic rst_n;
	logic word_mode;
	logic [18:0] addr;
	logic [15:0] dout;
	logic [15:0] doe;
	modport ctl (output ce_n, oe_n, we_n, rst_n, word_mode, addr, dout,
		doe);
	modport pad (input ce_n, oe_n, we_n, rst_n, word_mode, addr, dout,
		doe);
endinterface

// >>> rtl/bfh_pads.sv
// Pad stage: registered pin drivers and input synchronisers
module bfh_pads (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// From sequencer
	bfh_if.pad p,
	// Flash pins
	output logic ce_n,
	output logic oe_n,
	output logic we_n,
	output logic reset_n,
	output logic byte_n,
	output logic [18:0] addr,
	output logic [15:0] dq_out,
	output logic [15:0] dq_oe,
	input wire logic [15:0] dq_in,
	input wire logic ready_busy_in,
	// Synchronised back
	output logic [15:0] dq_sync,
	output logic rb_sync
);
	logic [15:0] dq_meta;
	logic rb_meta;
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			ce_n <= 1'b1;
			oe_n <= 1'b1;
			we_n <= 1'b1;
			reset_n <= 1'b0;
			byte_n <= 1'b1;
			addr <= 19'h00000;
			dq_out <= 16'h0000;
			dq_oe <= 16'h0000;
		end else begin
			ce_n <= p.ce_n;
			oe_n <= p.oe_n;
			we_n <= p.we_n;
			reset_n <= p.rst_n;
			byte_n <= p.word_mode;
			addr <= p.addr;
			dq_out <= p.dout;
			dq_oe <= p.doe;
		end
	end
	// Two stages; only the second is read
	always_ff @(posedge ref_clk) begin
		dq_meta <= dq_in;
		dq_sync <= dq_meta;
		rb_meta <= ready_busy_in;
		rb_sync <= rb_meta;
	end
endmodule // bfh_pads

// >>> rtl/bfh_pkg.sv
// Package: flash host constants, timing, operation codes and sector map
// What this block does
// - Byte mode: line 15 carries lowest address
// - Read: select and gate low, strobe high
// - Write: strobe and select low, gate high
// - Bypass mode programs in two cycles
// - Wait recovery time after reset release
package bfh_pkg;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_NS = 100;
	localparam int T_ACC_NS = 55;
	localparam int T_WP_NS = 35;
	localparam int T_RP_NS = 500;
	localparam int T_RH_NS = 50;
	localparam int T_READY_NS = 20000;
	localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS + 1;
	localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
	localparam int RP_CYC = (T_RP_NS + CLK_NS - 1) / CLK_NS;
	localparam int RH_CYC = (T_RH_NS + CLK_NS - 1) / CLK_NS;
	localparam int READY_CYC = T_READY_NS / CLK_NS;
	// ----------------------------------------
	// Operations and sequencer states
	// ----------------------------------------
	typedef enum logic [1:0] {
		BFH_OP_READ = 2'h0,
		BFH_OP_WRITE = 2'h1,
		BFH_OP_RESET = 2'h2
	} bfh_op_t;
	typedef enum logic [2:0] {
		BFH_IDLE = 3'h0,
		BFH_SETUP = 3'h1,
		BFH_STROBE = 3'h3,
		BFH_HOLD = 3'h2,
		BFH_RST = 3'h6,
		BFH_RWAIT = 3'h7
	} bfh_state_t;
	// ----------------------------------------
	// Sector map
	// ----------------------------------------
	localparam int SECT_HI = 18;
	localparam int SECT_LO = 12;
	localparam logic [4:0] SECT_ZERO = 5'h00;
	localparam logic [4:0] SECT_FIFTEEN = 5'h0F;
	localparam logic [4:0] SECT_EIGHTEEN = 5'h12;
	function automatic logic [4:0] sector_of(input logic [6:0] a);
		// Input is address bits 18 to 12
		if (a[6:3] != 4'hF)
			return {1'b0, a[6:3]};
		else if (!a[2])
			return SECT_FIFTEEN;
		else if (!a[1])
			return a[0] ? 5'h11 : 5'h10;
		else
			return SECT_EIGHTEEN;
	endfunction
endpackage

// >>> tb/bfh_flash_model.sv
// Behavioural boot-sector flash at the pins
module bfh_flash_model #(
	// Identification; values arbitrary
	parameter logic [7:0] ID_CMD = 8'h5A,
	parameter logic [7:0] ID_CODE = 8'hC3
) (
	// Pins
	input wire logic clk,
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic reset_n,
	input wire logic byte_n,
	input wire logic [18:0] addr,
	input wire logic [15:0] dq,
	// Device side
	output logic [15:0] d,
	output logic [15:0] en,
	output logic rb
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----
	// Array and busy
	// ----
	logic [3:0] busy = 4'h0;
	logic armed = 1'b0;
	logic ident = 1'b0;
	logic we_seen = 1'b0;
	logic wr;
	logic [15:0] w;
	assign w = addr[15:0] ^ 16'h3C5A;
	assign wr = reset_n && !ce_n && !we_n && oe_n;
	assign rb = busy == 4'h0;
	assign d = busy != 4'h0 ? 16'h0080 :
		ident ? {8'h00, ID_CODE} : byte_n ? w :
		{8'h00, dq[15] ? w[15:8] : w[7:0]};
	assign en = ce_n | oe_n | !reset_n ? 16'h0000 :
		byte_n ? 16'hFFFF : 16'h00FF;
	// Deselect does not stop the count
	always_ff @(posedge clk) begin
		we_seen <= wr;
		if (busy != 4'h0) begin
			busy <= !reset_n && busy > 4'h3 ? 4'h3 : busy - 4'h1;
		end else if (!reset_n) begin
			armed <= 1'b0;
			ident <= 1'b0;
		end else if (wr && !we_seen) begin
			// Stands in bypass mode: every second write programs
			busy <= armed ? 4'hF : 4'h0;
			armed <= !armed && !ident && dq[7:0] != ID_CMD;
			ident <= !armed && !ident && dq[7:0] == ID_CMD;
		end
	end
endmodule // bfh_flash_model

// >>> tb/bfh_host_checker.sv
// Pin protocol checks for the flash host
module bfh_host_checker (
	// Watched ports
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic reset_n,
	input wire logic byte_n,
	input wire logic [15:0] dq_oe,
	input wire logic ready_busy_out,
	input wire logic dev_busy
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----
	// Assertions
	// ----
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);
	a_read_strobe_off: assert property (
		!ce_n && !oe_n |-> we_n) else $error("strobe low in read");
	a_write_gate_off: assert property (
		!we_n |-> !ce_n && oe_n) else $error("bad write pins");
	a_byte_alow_drive: assert property (
		!ce_n && !byte_n |-> dq_oe[15]) else $error("A-1 undriven");
	a_byte_upper_free: assert property (
		!byte_n |-> dq_oe[14:8] == 7'h00) else $error("upper driven");
	a_read_no_drive: assert property (
		!oe_n |-> (dq_oe & {byte_n, 15'h7FFF}) == 16'h0000)
		else $error("drive while gated");
	a_reset_width: assert property (
		$fell(reset_n) |-> !reset_n [*5]) else $error("reset short");
	a_reset_recover: assert property (
		$rose(reset_n) |-> ce_n [*2]) else $error("early access");
	a_busy_follow: assert property (
		$stable(ready_busy_out) [*4] |-> dev_busy != ready_busy_out)
		else $error("busy wrong");
endmodule // bfh_host_checker

// >>> tb/tb_bfh_host.sv
// Self-checking bench for the flash host
module tb_bfh_host;
	timeunit 1ns;
	timeprecision 1ns;
	// Identification values; arbitrary
	localparam logic [7:0] ID_CMD = 8'h5A;
	localparam logic [7:0] ID_CODE = 8'hC3;
	// ----
	// Signals
	// ----
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic req_valid = 1'b0;
	logic req_word = 1'b0;
	bfh_pkg::bfh_op_t req_op = bfh_pkg::BFH_OP_READ;
	logic [19:0] req_addr = 20'h00000;
	logic [15:0] req_wdata = 16'h0000;
	logic [15:0] dq_last = 16'h0000;
	logic [15:0] rsp_rdata, dq_out, dq_oe, dq_in, m_d, m_en, got;
	logic [18:0] addr;
	logic [4:0] rsp_sector, sec;
	logic req_ready, rsp_valid, dev_busy, rb;
	logic ce_n, oe_n, we_n, reset_n, byte_n;
	int n_errors = 0;
	int samples_checked = 0;
	logic [19:0] sa [8] = '{20'h00000, 20'h1FFFF, 20'hE0000,
		20'hF7FFF, 20'hF8000, 20'hFBFFF, 20'hFC000, 20'hFFFFF};
	logic [4:0] se [8] = '{5'h00, 5'h01, 5'h0E, 5'h0F,
		5'h10, 5'h11, 5'h12, 5'h12};
	always #50 ref_clk = ~ref_clk;
	// Released lines show the inverse of their last level
	assign dq_in = (dq_oe & dq_out) | (~dq_oe & m_en & m_d)
		| (~dq_oe & ~m_en & ~dq_last);
	always @(posedge ref_clk) dq_last <= dq_in;
	bfh_host #(.READY_CYCLES(4)) dut (.ref_clk(ref_clk), .nrst(nrst),
		.req_valid(req_valid), .req_ready(req_ready), .req_op(req_op),
		.req_word(req_word), .req_addr(req_addr),
		.req_wdata(req_wdata), .rsp_valid(rsp_valid),
		.rsp_rdata(rsp_rdata), .rsp_sector(rsp_sector),
		.dev_busy(dev_busy), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
		.reset_n(reset_n), .byte_n(byte_n), .addr(addr),
		.dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in),
		.ready_busy_out(rb));
	bfh_flash_model #(.ID_CMD(ID_CMD), .ID_CODE(ID_CODE)) mdl (
		.clk(ref_clk), .ce_n(ce_n), .oe_n(oe_n),
		.we_n(we_n), .reset_n(reset_n), .byte_n(byte_n),
		.addr(addr), .dq(dq_in), .d(m_d), .en(m_en), .rb(rb));
	// ----
	// Tasks
	// ----
	task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic wt();
		int k;
		k = 0;
		while (dev_busy !== 1'b0 && k < 3000) begin
			@(negedge ref_clk);
			k++;
		end
		chk("idle", 16'h0000, {15'h0000, dev_busy});
	endtask
	task automatic op(bfh_pkg::bfh_op_t o, logic w, logic [19:0] a);
		int k;
		@(negedge ref_clk);
		for (k = 0; req_ready !== 1'b1 && k < 3000; k++)
			@(negedge ref_clk);
		req_op = o;
		req_word = w;
		req_addr = a;
		req_valid = 1'b1;
		@(negedge ref_clk);
		req_valid = 1'b0;
		for (k = 0; rsp_valid !== 1'b1 && k < 3000; k++)
			@(negedge ref_clk);
		chk("answer", 16'h0001, {15'h0000, rsp_valid});
		got = rsp_rdata;
		sec = rsp_sector;
	endtask
	function automatic logic [15:0] arr(logic [19:0] b, logic w);
		logic [15:0] v;
		v = (w ? b[15:0] : b[16:1]) ^ 16'h3C5A;
		return w ? v : {8'h00, b[0] ? v[15:8] : v[7:0]};
	endfunction
	task automatic t_reads();
		for (int i = 0; i < 8; i++) begin
			op(bfh_pkg::BFH_OP_READ, 1'b0, sa[i]);
			chk("byte", arr(sa[i], 1'b0), got);
			chk("sec", 16'(se[i]), 16'(sec));
			op(bfh_pkg::BFH_OP_READ, 1'b1, {1'b0, sa[i][19:1]});
			chk("word", arr({1'b0, sa[i][19:1]}, 1'b1), got);
			chk("wsec", 16'(se[i]), 16'(sec));
		end
		$display("test reads done");
	endtask
	task automatic t_ident();
		req_wdata = {8'h00, ID_CMD};
		op(bfh_pkg::BFH_OP_WRITE, 1'b0, 20'h00AAA);
		op(bfh_pkg::BFH_OP_READ, 1'b0, 20'h00000);
		chk("ident", {8'h00, ID_CODE}, got);
		req_wdata = 16'h00F0;
		op(bfh_pkg::BFH_OP_WRITE, 1'b0, 20'h00000);
		op(bfh_pkg::BFH_OP_READ, 1'b0, 20'h00001);
		chk("leave ident", arr(20'h00001, 1'b0), got);
		$display("test ident done");
	endtask
	task automatic t_status();
		req_wdata = 16'h00A0;
		op(bfh_pkg::BFH_OP_WRITE, 1'b1, 20'h00555);
		op(bfh_pkg::BFH_OP_READ, 1'b1, 20'h00555);
		chk("one write", arr(20'h00555, 1'b1), got);
		req_wdata = 16'h1234;
		op(bfh_pkg::BFH_OP_WRITE, 1'b1, 20'h00555);
		op(bfh_pkg::BFH_OP_READ, 1'b1, 20'h00555);
		chk("status", 16'h0080, got);
		chk("busy", 16'h0001, {15'h0000, dev_busy});
		wt();
		op(bfh_pkg::BFH_OP_READ, 1'b1, 20'h00555);
		chk("after busy", arr(20'h00555, 1'b1), got);
		$display("test status done");
	endtask
	task automatic t_reset();
		op(bfh_pkg::BFH_OP_WRITE, 1'b0, 20'h00AAA);
		op(bfh_pkg::BFH_OP_WRITE, 1'b0, 20'h00AAA);
		op(bfh_pkg::BFH_OP_RESET, 1'b0, 20'h00000);
		chk("ready", 16'h0000, {15'h0000, dev_busy});
		op(bfh_pkg::BFH_OP_READ, 1'b0, 20'h00AAB);
		chk("post reset", arr(20'h00AAB, 1'b0), got);
		op(bfh_pkg::BFH_OP_WRITE, 1'b0, 20'h00AAA);
		op(bfh_pkg::BFH_OP_WRITE, 1'b0, 20'h00AAA);
		op(bfh_pkg::BFH_OP_READ, 1'b0, 20'h00AAB);
		chk("restart", 16'h0080, got);
		wt();
		$display("test reset done");
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (12) @(negedge ref_clk);
		nrst = 1'b1;
		t_reads();
		t_ident();
		t_status();
		t_reset();
		print_verdict();
	end
	initial begin
		#300000;
		n_errors++;
		print_verdict();
	end
endmodule // tb_bfh_host
bind bfh_host bfh_host_checker chk_i (.ref_clk(ref_clk), .nrst(nrst),
	.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .reset_n(reset_n),
	.byte_n(byte_n), .dq_oe(dq_oe), .ready_busy_out(ready_busy_out),
	.dev_busy(dev_busy));
